// >>> logic/pmt_map.vh
// register offsets, field positions and reset values of the timer channel
`ifndef PMT_MAP_VH
`define PMT_MAP_VH
`define PMT_OFS_START 12'h000
`define PMT_OFS_MODE 12'h004
`define PMT_OFS_COUNT 12'h008
`define PMT_OFS_STAT 12'h00c
`define PMT_OFS_MASK 12'h010
`define PMT_OFS_PIN 12'h014
`define PMT_BIT_MODE_LO 0
`define PMT_BIT_MODE_HI 1
`define PMT_BIT_MSEL_LO 2
`define PMT_BIT_MSEL_HI 3
`define PMT_BIT_RSVD4 4
`define PMT_BIT_OVF 5
`define PMT_BIT_SUBSEL 6
`define PMT_BIT_EVSEL 7
`define PMT_MODE_TIMER 2'h0
`define PMT_MODE_EVENT 2'h1
`define PMT_MODE_MEASURE 2'h2
`define PMT_MSEL_PER_RISE 2'h0
`define PMT_MSEL_PER_FALL 2'h1
`define PMT_MSEL_WIDTH 2'h2
`define PMT_RST_MODE 8'h00
`define PMT_RST_COUNT 16'h0000
`define PMT_ALL_ONES 16'hffff
`define PMT_SYNC_STAGES 3
`endif

// >>> logic/pmt_timer.v
// one 16-bit timer channel with measurement modes and an apb register slave
`timescale 1ns/1ns
`include "pmt_map.vh"
module pmt_timer #(
	parameter WIDTH = 16
)(
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire count_tick,
	input wire alt_count_tick,
	input wire other_timer_irq,
	input wire measure_input_pin,
	output wire timer_event,
	output wire irq
);

////////////////////////////////////////////////////////////////////////
// apb decode
//
// every register is one aligned word; only the low bits carry state and
// the upper bits read as zero. the slave never inserts wait states:
// the read mux is sampled into prdata in the setup cycle, so the data
// already stands when the access cycle signals ready. a write lands at
// the access edge only, never in setup, so a master that holds its
// request steady through the access cycle sees exactly one update.
// unmapped offsets answer with an error in the access phase, their
// writes are dropped and their reads return zero.

	wire setup_ph;
	wire acc_ph;
	wire wr_en;
	wire hit;
	assign setup_ph = psel & ~penable;
	assign acc_ph = psel & penable;
	assign wr_en = acc_ph & pwrite;
	assign hit = (paddr == `PMT_OFS_START) | (paddr == `PMT_OFS_MODE)
		| (paddr == `PMT_OFS_COUNT) | (paddr == `PMT_OFS_STAT)
		| (paddr == `PMT_OFS_MASK) | (paddr == `PMT_OFS_PIN);
	// read data is captured in setup, so every access takes two cycles
	assign pready = acc_ph;
	assign pslverr = acc_ph & ~hit;

	wire wr_start;
	wire wr_mode;
	wire wr_count;
	wire wr_stat;
	wire wr_mask;
	assign wr_start = wr_en & (paddr == `PMT_OFS_START);
	assign wr_mode = wr_en & (paddr == `PMT_OFS_MODE);
	assign wr_count = wr_en & (paddr == `PMT_OFS_COUNT);
	assign wr_stat = wr_en & (paddr == `PMT_OFS_STAT);
	assign wr_mask = wr_en & (paddr == `PMT_OFS_MASK);

////////////////////////////////////////////////////////////////////////
// control registers
//
// the start and mask bits may flip at any time, and a count write in timer or event mode still reaches the reload while running. the
// mode, measurement select and source selects are frozen while the
// channel runs: a write then only reaches the overflow flag clear, so a
// careless running write cannot switch the counting direction under a
// live count. the trade-off is that software has to stop the channel,
// reprogram it and start it again, which also restarts the first-edge
// bookkeeping in the measurement modes.

	reg run_q;
	reg [1:0] op_mode_q;
	reg [1:0] msel_q;
	reg subsel_q;
	reg evsel_q;
	reg stat_q;
	reg mask_q;

	// count start bit; stopped after reset until software sets it
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			run_q <= 1'b0;
		else if (wr_start)
			run_q <= pwdata[0];
	end

	// configuration only takes a write while stopped
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			op_mode_q <= `PMT_MODE_TIMER;
			msel_q <= `PMT_MSEL_PER_RISE;
			subsel_q <= 1'b0;
			evsel_q <= 1'b0;
		end
		else if (wr_mode && !run_q)
		begin
			op_mode_q <= pwdata[`PMT_BIT_MODE_HI:`PMT_BIT_MODE_LO];
			msel_q <= pwdata[`PMT_BIT_MSEL_HI:`PMT_BIT_MSEL_LO];
			subsel_q <= pwdata[`PMT_BIT_SUBSEL];
			evsel_q <= pwdata[`PMT_BIT_EVSEL];
		end
	end

////////////////////////////////////////////////////////////////////////
// measurement pin: three stages, a change counts once stages two and three agree

	reg [`PMT_SYNC_STAGES-1:0] pin_sync_q;
	reg pin_lvl_q;
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_sync_q <= 3'h0;
			pin_lvl_q <= 1'b0;
		end
		else
		begin
			pin_sync_q <= {pin_sync_q[1:0], measure_input_pin};
			if (pin_sync_q[1] == pin_sync_q[2])
				pin_lvl_q <= pin_sync_q[2];
		end
	end

	wire pin_rise;
	wire pin_fall;
	assign pin_rise = (pin_sync_q[1] == pin_sync_q[2]) & pin_sync_q[2] & ~pin_lvl_q;
	assign pin_fall = (pin_sync_q[1] == pin_sync_q[2]) & ~pin_sync_q[2] & pin_lvl_q;

////////////////////////////////////////////////////////////////////////
// count enables and edge selection

	wire measuring;
	wire tick;
	wire ev_tick;
	wire act_edge;
	assign measuring = (op_mode_q == `PMT_MODE_MEASURE);
	// the alternate source (e.g. main clock) is only valid while f1 runs
	assign tick = subsel_q ? alt_count_tick : count_tick;
	// chained request arrives unmasked, whatever the other side's enables
	assign ev_tick = evsel_q ? other_timer_irq : pin_fall;

	reg edge_sel;
	always @*
	begin
		case (msel_q)
			`PMT_MSEL_PER_RISE: edge_sel = pin_rise;
			`PMT_MSEL_PER_FALL: edge_sel = pin_fall;
			`PMT_MSEL_WIDTH: edge_sel = pin_rise | pin_fall;
			default: edge_sel = pin_rise;
		endcase
	end
	assign act_edge = run_q & measuring & edge_sel;

////////////////////////////////////////////////////////////////////////
// counter, reload and edge bookkeeping
//
// timer and event modes count down and reload on the step past zero.
// measurement counts up on the tick; each accepted edge moves the count
// into the reload register and restarts the counter from zero. the very
// first edge after a start only primes the reload, because the count
// before it does not span a whole period or level. a stopped counter
// write lands in both counter and reload in every mode, so a read made
// before the start returns the value just written. the counter resets
// to zero here; software must not rely on that value, since counting
// from it may overflow before any edge is seen.

	reg [WIDTH-1:0] cnt_q;
	reg [WIDTH-1:0] rld_q;
	reg seen_edge_q;
	reg ovf_q;
	reg run_d1_q;

	wire start_pulse;
	wire step;
	wire underflow;
	wire overflow;
	wire edge_ok;
	wire edge_req;
	wire reloading;
	assign start_pulse = run_q & ~run_d1_q;
	// timer counts the tick, event mode the selected event, both downward
	assign step = run_q & ((op_mode_q == `PMT_MODE_TIMER) ? tick
		: (op_mode_q == `PMT_MODE_EVENT) ? ev_tick : 1'b0);
	assign underflow = step & (cnt_q == {WIDTH{1'b0}});
	// counting up from whatever sits in the counter can overflow first
	assign overflow = run_q & measuring & tick & (cnt_q == {WIDTH{1'b1}});
	// a period edge meeting an overflow is dropped, one request only
	assign edge_ok = act_edge & ~(overflow & (msel_q != `PMT_MSEL_WIDTH));
	// the first edge after start only primes the reload, silently
	assign edge_req = edge_ok & seen_edge_q;
	assign reloading = underflow;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			run_d1_q <= 1'b0;
		else
			run_d1_q <= run_q;
	end

	// counter path
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_q <= `PMT_RST_COUNT;
		else if (wr_count && !run_q)
			cnt_q <= pwdata[WIDTH-1:0];
		else if (edge_ok)
			cnt_q <= {WIDTH{1'b0}};
		else if (run_q && measuring && tick)
			cnt_q <= cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
		else if (underflow)
			cnt_q <= rld_q;
		else if (step)
			cnt_q <= cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
	end

	// reload path: software value, or the captured count in measurement
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rld_q <= `PMT_RST_COUNT;
		else if (edge_ok)
			rld_q <= cnt_q;
		else if (wr_count && (!run_q || !measuring))
			rld_q <= pwdata[WIDTH-1:0];
	end

	// first-edge tracking restarts with each count start
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			seen_edge_q <= 1'b0;
		else if (start_pulse)
			seen_edge_q <= 1'b0;
		else if (edge_ok)
			seen_edge_q <= 1'b1;
	end

	// overflow flag: a running mode write with bit 4 low clears it, a new overflow wins
	wire ovf_clr;
	assign ovf_clr = wr_mode & run_q & ~pwdata[`PMT_BIT_RSVD4];
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ovf_q <= 1'b0;
		else if (overflow)
			ovf_q <= 1'b1;
		else if (ovf_clr)
			ovf_q <= 1'b0;
	end

////////////////////////////////////////////////////////////////////////
// request, status and interrupt
//
// the request pulse feeds two places: the sticky status bit behind the
// mask, and the event output that chains into other timers. the chain
// takes the raw pulse so that a neighbour keeps counting even while
// this channel's interrupt is masked off. in measurement modes software
// tells an edge from an overflow only through the overflow flag.

	wire req;
	// measurement raises a request on each counted edge and on overflow
	assign req = underflow | (measuring & (edge_req | overflow));
	// the event out to other timers is the raw request, never masked
	assign timer_event = req;

	// sticky request flag, write one to clear, a new request wins
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			stat_q <= 1'b0;
		else if (req)
			stat_q <= 1'b1;
		else if (wr_stat && pwdata[0])
			stat_q <= 1'b0;
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mask_q <= 1'b0;
		else if (wr_mask)
			mask_q <= pwdata[0];
	end

	assign irq = stat_q & mask_q;

////////////////////////////////////////////////////////////////////////
// read mux, sampled in the setup cycle

	// stopped: the counter as it stands, the last stopped write or where the run left it
	// running timer or event: the live count, all ones while reloading
	// running measurement: the last captured result in the reload register
	// limitation: a read that meets a reload cannot see the live count
	reg [WIDTH-1:0] cnt_view;
	always @*
	begin
		cnt_view = cnt_q;
		if (!run_q)
			cnt_view = cnt_q;
		else if (measuring)
			cnt_view = rld_q;
		else if (reloading)
			cnt_view = `PMT_ALL_ONES;
		else
			cnt_view = cnt_q;
	end

	reg [31:0] rd_d;
	always @*
	begin
		rd_d = 32'h0000_0000;
		case (paddr)
			`PMT_OFS_START: rd_d[0] = run_q;
			`PMT_OFS_MODE:
			begin
				rd_d[`PMT_BIT_MODE_HI:`PMT_BIT_MODE_LO] = op_mode_q;
				rd_d[`PMT_BIT_MSEL_HI:`PMT_BIT_MSEL_LO] = msel_q;
				rd_d[`PMT_BIT_OVF] = ovf_q;
				rd_d[`PMT_BIT_SUBSEL] = subsel_q;
				rd_d[`PMT_BIT_EVSEL] = evsel_q;
			end
			`PMT_OFS_COUNT: rd_d[WIDTH-1:0] = cnt_view;
			`PMT_OFS_STAT: rd_d[0] = stat_q;
			`PMT_OFS_MASK: rd_d[0] = mask_q;
			`PMT_OFS_PIN: rd_d[0] = pin_lvl_q;
			default: rd_d = 32'h0000_0000;
		endcase
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (setup_ph && !pwrite)
			prdata <= rd_d;
	end

endmodule // pmt_timer

// >>> verification/pmt_far_model.sv
// far side: count sources, other timer requests, measured pin
`timescale 1ns/1ns
module pmt_far_model (
	input wire pclk,
	input wire [2:0] src_en,
	input wire pin_en,
	output reg count_tick = 1'b0,
	output reg alt_count_tick = 1'b0,
	output reg other_timer_irq = 1'b0,
	output reg measure_input_pin = 1'b0
);
reg [2:0] r;
reg [3:0] pc = 4'h0;
// random one-cycle pulses; ticks every cycle while the pin toggles
always @(posedge pclk)
begin
	r = $urandom;
	count_tick <= src_en[0] & (r[0] | pin_en);
	alt_count_tick <= src_en[1] & r[1];
	other_timer_irq <= src_en[2] & r[2];
	pc <= (pin_en && pc != 4'h9) ? pc + 4'h1 : 4'h0;
	if (pin_en && pc == 4'h9)
		measure_input_pin <= ~measure_input_pin;
end
endmodule // pmt_far_model

// >>> verification/pmt_timer_properties.sv
// port checks of the timer channel
`timescale 1ns/1ns
module pmt_timer_chk (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire timer_event,
	input wire irq
);
wire wr_acc = psel && penable && pwrite;
wire rd_set = psel && !penable && !pwrite;
wire bad_a = paddr > 12'h014;
reg run_q;
reg fresh_q;
reg mask_q;
reg [15:0] cnt_q;
////////////////////////////////
// shadows of start, mask and stopped count writes
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		run_q <= 1'b0;
		fresh_q <= 1'b1;
		mask_q <= 1'b0;
		cnt_q <= 16'h0000;
	end
	else if (wr_acc)
	begin
		if (paddr == 12'h000)
			run_q <= pwdata[0];
		if (paddr == 12'h010)
			mask_q <= pwdata[0];
		if (paddr == 12'h008 && !run_q)
			cnt_q <= pwdata[15:0];
		// a running count is live, so only a stopped write is known
		fresh_q <= (paddr == 12'h008 && !run_q) || (fresh_q && !(paddr == 12'h000 && pwdata[0]));
	end
end
////////////////////////////////
default clocking @(posedge pclk);
endclocking
default disable iff (!presetn);
a_ready_now: assert property (pready == (psel && penable))
	else $error("pready off access phase");
a_stop_quiet: assert property (!run_q |-> !timer_event)
	else $error("request while stopped");
a_stop_read: assert property (
	rd_set && paddr == 12'h008 && fresh_q |=> prdata == {16'h0000, cnt_q})
	else $error("stopped count read wrong");
a_unmapped_err: assert property (psel && penable && bad_a |-> pslverr)
	else $error("no error on unmapped access");
a_unmapped_zero: assert property (rd_set && bad_a |=> prdata == 32'h0)
	else $error("unmapped read not zero");
a_upper_zero: assert property (rd_set |=> prdata[31:16] == 16'h0000)
	else $error("upper read bits set");
a_irq_masked: assert property (!mask_q |-> !irq)
	else $error("masked request on irq");
a_irq_follows: assert property (
	timer_event && mask_q && !(wr_acc && paddr == 12'h010) |=> irq)
	else $error("request did not raise irq");
endmodule // pmt_timer_chk
bind pmt_timer pmt_timer_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .timer_event(timer_event), .irq(irq));

// >>> verification/pmt_timer_test.sv
// self-checking bench of the timer channel
`timescale 1ns/1ns
module pmt_timer_test;
reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pin_en = 1'b0;
reg [2:0] src_en = 3'h0;
reg [11:0] paddr = 12'h000;
reg [31:0] pwdata = 32'h0, v;
reg [15:0] n;
wire [31:0] prdata;
wire pready, tick, alt, oirq, pin, timer_event, irq;
integer num_errors = 0, check_count = 0, ev_n = 0, pu_n = 0, e0, p0, i;
always #25 pclk = ~pclk;
pmt_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(), .count_tick(tick), .alt_count_tick(alt), .other_timer_irq(oirq),
	.measure_input_pin(pin), .timer_event(timer_event), .irq(irq));
pmt_far_model u_far (.pclk(pclk), .src_en(src_en), .pin_en(pin_en), .count_tick(tick),
	.alt_count_tick(alt), .other_timer_irq(oirq), .measure_input_pin(pin));
////////////////////////////////
// tally requests and source pulses
always @(posedge pclk)
begin
	ev_n <= ev_n + timer_event;
	pu_n <= pu_n + (tick | alt | oirq);
end
// count left after a reload, less the pulses past the underflow
function [31:0] left(input [31:0] ld, input [31:0] pulses);
	left = ld - (pulses - ld - 1);
endfunction
task chk(input [31:0] s, input [31:0] e);
	check_count = check_count + 1;
	if (s !== e)
	begin
		num_errors = num_errors + 1;
		$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
	end
endtask
// setup, then access held until pready is seen at an edge
task apb(input w, input [11:0] a, input [31:0] d);
	psel <= 1'b1;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	@(posedge pclk);
	penable <= 1'b1;
	@(posedge pclk);
	while (pready !== 1'b1)
		@(posedge pclk);
	v = prdata;
	psel <= 1'b0;
	penable <= 1'b0;
	@(posedge pclk);
endtask
task rc(input [11:0] a, input [31:0] e);
	apb(1'b0, a, 32'h0);
	chk(v, e);
endtask
task wrap_up;
	$display("errors=%0d checks=%0d", num_errors, check_count);
	if (num_errors == 0 && check_count > 0)
		$display("TB: PASS");
	else
		$display("TB: FAIL");
	$finish;
endtask
////////////////////////////////
initial
begin
	v = $urandom(4417);
	repeat (6) @(posedge pclk);
	presetn <= 1'b1;
	@(posedge pclk);
	rc(12'h000, 32'h0);
	rc(12'h018, 32'h0);
	n = $urandom;
	apb(1'b1, 12'h008, {16'h0, n});
	rc(12'h008, {16'h0, n});
	// timer on both sources, then event mode with the mask off
	for (i = 0; i < 3; i = i + 1)
	begin
		n = 16'h2 + $urandom % 8;
		apb(1'b1, 12'h000, 32'h0);
		apb(1'b1, 12'h004, i == 0 ? 32'h00 : i == 1 ? 32'h40 : 32'h81);
		apb(1'b1, 12'h008, {16'h0, n});
		apb(1'b1, 12'h010, {31'h0, i != 2});
		apb(1'b1, 12'h000, 32'h1);
		e0 = ev_n;
		p0 = pu_n;
		src_en <= 3'h1 << i;
		wait (ev_n != e0);
		src_en <= 3'h0;
		chk(pu_n - p0, n + 32'h1);
		repeat (3) @(posedge pclk);
		rc(12'h008, left(n, pu_n - p0));
		chk({31'h0, irq}, {31'h0, i != 2});
		rc(12'h00c, 32'h1);
		apb(1'b1, 12'h00c, 32'h1);
		rc(12'h00c, 32'h0);
	end
	// overflow from a stopped load, flag cleared while running
	apb(1'b1, 12'h000, 32'h0);
	apb(1'b1, 12'h004, 32'h02);
	apb(1'b1, 12'h008, 32'hfff0);
	rc(12'h008, 32'hfff0);
	apb(1'b1, 12'h000, 32'h1);
	e0 = ev_n;
	p0 = pu_n;
	src_en <= 3'h1;
	wait (ev_n != e0);
	src_en <= 3'h0;
	chk(pu_n - p0, 16);
	rc(12'h004, 32'h22);
	apb(1'b1, 12'h004, 32'h02);
	rc(12'h004, 32'h02);
	// width mode: first edge silent, then one result per level
	apb(1'b1, 12'h000, 32'h0);
	apb(1'b1, 12'h004, 32'h0a);
	apb(1'b1, 12'h000, 32'h1);
	e0 = ev_n;
	src_en <= 3'h1;
	pin_en <= 1'b1;
	repeat (18) @(posedge pclk);
	chk(ev_n - e0, 0);
	wait (ev_n != e0);
	p0 = pu_n;
	wait (ev_n != e0 + 1);
	chk(pu_n - p0, 10);
	pin_en <= 1'b0;
	src_en <= 3'h0;
	repeat (8) @(posedge pclk);
	rc(12'h014, {31'h0, pin});
	wrap_up;
end
// cut a hang short
initial
begin
	#2000000;
	num_errors = num_errors + 1;
	wrap_up;
end
endmodule // pmt_timer_test
